// ---- hw/msc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the soft control block
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_CLK_MHZ        25
`define MSC_RST_MIN_US     10
`define MSC_RST_MIN_CYC    (`MSC_RST_MIN_US * `MSC_CLK_MHZ)
`define MSC_INIT_MAX_MS    2000
`define MSC_INIT_MAX_CYC   (`MSC_INIT_MAX_MS * 1000 * `MSC_CLK_MHZ)
`define MSC_INIT_W         26
`define MSC_LOWCNT_W       9

`define MSC_OFF_CTRL       8'h1A
`define MSC_OFF_TXF_MASK   8'h40
`define MSC_OFF_RXL_MASK   8'h41
`define MSC_OFF_PAGE       8'h7F
`define MSC_OFF_TX_DIS     8'h82
`define MSC_OFF_TX_SQ      8'h83
`define MSC_OFF_TXF        8'h87
`define MSC_OFF_RX_DIS     8'h8A
`define MSC_OFF_RX_SQ      8'h8B
`define MSC_OFF_RXL        8'h93
`define MSC_OFF_ADV_WAIT   8'h8F
`define MSC_OFF_ADV_DP     8'h90
`define MSC_OFF_ADV_PWR    8'hA7

`define MSC_PAGE_ADV       8'h01
`define MSC_PAGE_CTL       8'h10
`define MSC_PAGE_FLG       8'h11

`define MSC_BIT_SOFT_LP    6
`define MSC_BIT_SQ_MODE    5
`define MSC_BIT_FORCE_LP   4
`define MSC_BIT_SW_RST     3
`define MSC_CTRL_KEEP      8'h70
`define MSC_CTRL_RST       8'h00
`define MSC_ZERO_BYTE      8'h00

`endif

// ---- hw/msc_pkg.sv ----
// Types shared by the soft control block
`include "msc_cfg.svh"
package msc_pkg;

    typedef enum logic [3:0] {
        MSC_IDLE, MSC_ADDR, MSC_ADDR_ACK, MSC_REG, MSC_REG_ACK,
        MSC_WR, MSC_WR_ACK, MSC_RD, MSC_RD_ACK
    } msc_bus_state_t;

    // Per-lane monitor conditions from the analog front end
    typedef struct packed {
        logic [7:0] tx_fault;
        logic [7:0] tx_los;
        logic [7:0] rx_los;
    } msc_lane_cond_t;

    typedef struct packed {
        logic                     scl_s1, scl_s2, scl_s3;
        logic                     sda_s1, sda_s2, sda_s3;
        logic                     sel_s1, sel_s2;
        logic                     lp_s1, lp_s2;
        logic                     rst_s1, rst_s2;
        msc_lane_cond_t           cond_s1, cond_s2;
        logic                     in_rst;
        logic [`MSC_LOWCNT_W-1:0] low_cnt;
        logic [`MSC_INIT_W-1:0]   init_cnt;
        logic [7:0]               ctrl, page, tx_dis, rx_dis;
        logic [7:0]               txf_flags, rxl_flags, txf_mask, rxl_mask;
        logic [3:0]               shutdown;
        msc_bus_state_t           bus;
        logic [7:0]               sh, ptr;
        logic [3:0]               bc;
        logic                     rw;
        logic                     sda_oe, attn_oe, drive_lo;
        logic [3:0]               tx_off;
        logic [7:0]               tx_mod_off, rx_off;
        logic                     sq_mode, low_pwr, init_busy;
    } msc_state_t;

endpackage

// ---- hw/msc_core.sv ----
// Management control and status logic of the transceiver, with two-wire slave
//
// Notes on behaviour
// - Latch per-lane transmitter fault flag when laser power nears eye-safety limit.
// - A transmitter fault switches off that channel's optical output.
// - Faulted channel recovers on reset or disable toggle, if fault gone.
// - Fault flags latch and clear when the host reads them.
// - Forced power-save bit set puts the module into low power.
// - Otherwise low power needs soft power-save bit and pin both high.
// - Software reset bit with reset pin high acts as a pin reset.
// - Two electrical disable bits map to one optical source; either turns it off.
// - Receiver disable bit turns off that lane's electrical output.
// - Squelch override registers do nothing; squelch always enabled.
// - Squelched transmitter lane turns off modulation per squelch mode bit.
// - Management initialisation completes within 2000 ms of reset release.
// - Reset pin low at least 10 us starts a full module reset.
// - Flag condition sets flag and asserts attention within 200 ms.
// - Attention releases within 500 us after clear-on-read of the flag.
// - Receiver loss of signal sets its flag and attention within 100 ms.
// - Transmitter fault sets its flag and attention within 200 ms.
// - Squelch entry and exit within 15 ms receive, 400 ms transmit.
// - Transmitter disable takes effect within 100 ms, release within 400 ms.
// - Receiver disable set or clear takes effect within 100 ms.
// - Advertising page reports select wait and transition durations.
// - Attention releases only when every unmasked flag has been cleared.
`timescale 1ns/1ps
`include "msc_cfg.svh"
module msc_core #(
    parameter logic [6:0]            DEV_ADDR    = 7'h50,
    parameter logic [`MSC_INIT_W-1:0] INIT_CYCLES = `MSC_INIT_W'(`MSC_INIT_MAX_CYC),
    parameter logic [7:0]            ADV_WAIT    = 8'h00,
    parameter logic [7:0]            ADV_DP      = 8'h00,
    parameter logic [7:0]            ADV_PWR     = 8'h00
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    // Two-wire management bus
    input  wire logic                    scl_pin,
    input  wire logic                    sda_pin_in,
    output logic                         sda_pin_out,
    output logic                         sda_pin_oe,
    // Control pins
    input  wire logic                    module_select_pin_n,
    input  wire logic                    power_save_pin,
    input  wire logic                    module_reset_pin_n,
    output logic                         attention_pin_n_out,
    output logic                         attention_pin_n_oe,
    // Optical front end
    input  wire msc_pkg::msc_lane_cond_t lane_cond,
    output logic [3:0]                   tx_optical_off,
    output logic [7:0]                   tx_mod_off,
    output logic                         squelch_mode_sel,
    output logic [7:0]                   rx_output_off,
    output logic                         low_power_mode,
    output logic                         mgmt_init_busy
);
    import msc_pkg::*;

    msc_state_t q;
    msc_state_t d;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rd_byte(input msc_state_t s);
        logic [7:0] v;
        v = `MSC_ZERO_BYTE;
        if (s.ptr == `MSC_OFF_CTRL) begin
            v = s.ctrl;
        end else if (s.ptr == `MSC_OFF_PAGE) begin
            v = s.page;
        end else if (s.ptr == `MSC_OFF_TXF_MASK) begin
            v = s.txf_mask;
        end else if (s.ptr == `MSC_OFF_RXL_MASK) begin
            v = s.rxl_mask;
        end else if (s.page == `MSC_PAGE_CTL && s.ptr == `MSC_OFF_TX_DIS) begin
            v = s.tx_dis;
        end else if (s.page == `MSC_PAGE_CTL && s.ptr == `MSC_OFF_RX_DIS) begin
            v = s.rx_dis;
        end else if (s.page == `MSC_PAGE_FLG && s.ptr == `MSC_OFF_TXF) begin
            v = s.txf_flags;
        end else if (s.page == `MSC_PAGE_FLG && s.ptr == `MSC_OFF_RXL) begin
            v = s.rxl_flags;
        end else if (s.page == `MSC_PAGE_ADV && s.ptr == `MSC_OFF_ADV_WAIT) begin
            v = ADV_WAIT;
        end else if (s.page == `MSC_PAGE_ADV && s.ptr == `MSC_OFF_ADV_DP) begin
            v = ADV_DP;
        end else if (s.page == `MSC_PAGE_ADV && s.ptr == `MSC_OFF_ADV_PWR) begin
            v = ADV_PWR;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       scl_rise, scl_fall, start_c, stop_c, hold_ok, bus_ok;
        logic [7:0] clr_tx, clr_rx, v;
        scl_rise = q.scl_s2 & ~q.scl_s3;
        scl_fall = ~q.scl_s2 & q.scl_s3;
        start_c  = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
        stop_c   = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
        clr_tx   = `MSC_ZERO_BYTE;
        clr_rx   = `MSC_ZERO_BYTE;
        v        = `MSC_ZERO_BYTE;
        d        = q;

        // Two-stage synchronisers for every pin and front-end level
        d.scl_s1  = scl_pin;
        d.scl_s2  = q.scl_s1;
        d.scl_s3  = q.scl_s2;
        d.sda_s1  = sda_pin_in;
        d.sda_s2  = q.sda_s1;
        d.sda_s3  = q.sda_s2;
        d.sel_s1  = module_select_pin_n;
        d.sel_s2  = q.sel_s1;
        d.lp_s1   = power_save_pin;
        d.lp_s2   = q.lp_s1;
        d.rst_s1  = module_reset_pin_n;
        d.rst_s2  = q.rst_s1;
        d.cond_s1 = lane_cond;
        d.cond_s2 = q.cond_s1;

        // Glitches shorter than the minimum pulse are ignored
        if (q.rst_s2) begin
            d.low_cnt = '0;
        end else if (q.low_cnt != `MSC_LOWCNT_W'(`MSC_RST_MIN_CYC)) begin
            d.low_cnt = q.low_cnt + `MSC_LOWCNT_W'(1);
        end
        hold_ok = ~q.rst_s2 && q.low_cnt == `MSC_LOWCNT_W'(`MSC_RST_MIN_CYC);
        bus_ok  = ~q.in_rst && ~q.init_busy && ~q.sel_s2;

        if (q.in_rst) begin
            // Full reset: settings back to default, init restarts on release
            d.in_rst    = hold_ok;
            d.init_cnt  = INIT_CYCLES;
            d.ctrl      = `MSC_CTRL_RST;
            d.page      = `MSC_ZERO_BYTE;
            d.tx_dis    = `MSC_ZERO_BYTE;
            d.rx_dis    = `MSC_ZERO_BYTE;
            d.txf_flags = `MSC_ZERO_BYTE;
            d.rxl_flags = `MSC_ZERO_BYTE;
            d.txf_mask  = `MSC_ZERO_BYTE;
            d.rxl_mask  = `MSC_ZERO_BYTE;
            d.shutdown  = '0;
        end else begin
            d.in_rst = hold_ok;
            if (q.init_cnt != '0) begin
                d.init_cnt = q.init_cnt - `MSC_INIT_W'(1);
            end
        end

        // Two-wire slave; deselect aborts any transfer in flight
        if (!bus_ok || stop_c) begin
            d.bus    = MSC_IDLE;
            d.sda_oe = 1'b0;
        end else if (start_c) begin
            d.bus    = MSC_ADDR;
            d.bc     = '0;
            d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (q.bus)
                MSC_ADDR, MSC_REG, MSC_WR: begin
                    d.sh = {q.sh[6:0], q.sda_s2};
                    d.bc = q.bc + 4'h1;
                end
                MSC_RD_ACK: begin
                    if (q.sda_s2) begin
                        d.bus = MSC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (q.bus)
                MSC_ADDR: begin
                    if (q.bc == 4'h8 && q.sh[7:1] == DEV_ADDR) begin
                        d.bus    = MSC_ADDR_ACK;
                        d.rw     = q.sh[0];
                        d.sda_oe = 1'b1;
                    end else if (q.bc == 4'h8) begin
                        d.bus = MSC_IDLE;
                    end
                end
                MSC_REG: begin
                    if (q.bc == 4'h8) begin
                        d.ptr    = q.sh;
                        d.bus    = MSC_REG_ACK;
                        d.sda_oe = 1'b1;
                    end
                end
                MSC_REG_ACK, MSC_WR_ACK: begin
                    d.bus    = MSC_WR;
                    d.bc     = '0;
                    d.sda_oe = 1'b0;
                end
                MSC_WR: begin
                    if (q.bc == 4'h8) begin
                        d.bus    = MSC_WR_ACK;
                        d.sda_oe = 1'b1;
                        d.ptr    = q.ptr + 8'h01;
                        if (q.ptr == `MSC_OFF_CTRL) begin
                            d.ctrl = q.sh & `MSC_CTRL_KEEP;
                            if (q.sh[`MSC_BIT_SW_RST] && q.rst_s2) begin
                                d.in_rst = 1'b1;
                            end
                        end else if (q.ptr == `MSC_OFF_PAGE) begin
                            d.page = q.sh;
                        end else if (q.ptr == `MSC_OFF_TXF_MASK) begin
                            d.txf_mask = q.sh;
                        end else if (q.ptr == `MSC_OFF_RXL_MASK) begin
                            d.rxl_mask = q.sh;
                        end else if (q.page == `MSC_PAGE_CTL && q.ptr == `MSC_OFF_TX_DIS) begin
                            d.tx_dis = q.sh;
                        end else if (q.page == `MSC_PAGE_CTL && q.ptr == `MSC_OFF_RX_DIS) begin
                            d.rx_dis = q.sh;
                        end
                        // Squelch override bytes fall through: acked, not stored
                    end
                end
                MSC_ADDR_ACK, MSC_RD_ACK: begin
                    if (q.bus == MSC_RD_ACK || q.rw) begin
                        v        = rd_byte(q);
                        d.sh     = v;
                        d.bc     = '0;
                        d.bus    = MSC_RD;
                        d.sda_oe = ~v[7];
                        d.ptr    = q.ptr + 8'h01;
                        if (q.page == `MSC_PAGE_FLG && q.ptr == `MSC_OFF_TXF) begin
                            clr_tx = v;
                        end
                        if (q.page == `MSC_PAGE_FLG && q.ptr == `MSC_OFF_RXL) begin
                            clr_rx = v;
                        end
                    end else begin
                        d.bus    = MSC_REG;
                        d.bc     = '0;
                        d.sda_oe = 1'b0;
                    end
                end
                MSC_RD: begin
                    if (q.bc == 4'h7) begin
                        d.bus    = MSC_RD_ACK;
                        d.sda_oe = 1'b0;
                    end else begin
                        d.sh     = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                        d.bc     = q.bc + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Latched flags: a new event in the read cycle survives the clear
        if (!q.in_rst) begin
            d.txf_flags = (q.txf_flags & ~clr_tx) | q.cond_s2.tx_fault;
            d.rxl_flags = (q.rxl_flags & ~clr_rx) | q.cond_s2.rx_los;
            for (int l = 0; l < 4; l++) begin
                if (q.cond_s2.tx_fault[2*l +: 2] != 2'b00) begin
                    d.shutdown[l] = 1'b1;
                end else if (q.tx_dis[2*l +: 2] != 2'b00 && d.tx_dis[2*l +: 2] == 2'b00) begin
                    d.shutdown[l] = 1'b0;
                end
            end
        end

        // Outputs, each one flop behind its cause
        d.attn_oe  = ((q.txf_flags & ~q.txf_mask) | (q.rxl_flags & ~q.rxl_mask))
                     != `MSC_ZERO_BYTE;
        for (int l = 0; l < 4; l++) begin
            d.tx_off[l] = q.shutdown[l] | (q.tx_dis[2*l +: 2] != 2'b00);
        end
        d.tx_mod_off = q.cond_s2.tx_los;
        d.sq_mode    = q.ctrl[`MSC_BIT_SQ_MODE];
        d.rx_off     = q.rx_dis | q.cond_s2.rx_los;
        d.low_pwr    = q.ctrl[`MSC_BIT_FORCE_LP]
                       | (q.ctrl[`MSC_BIT_SOFT_LP] & q.lp_s2);
        d.init_busy  = q.in_rst | (q.init_cnt != '0);
        d.drive_lo   = 1'b0;
    end

    // Power-on counts as a reset, so init runs after every power-up
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q        <= '0;
            q.in_rst <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_pin_out         = q.drive_lo;
    assign sda_pin_oe          = q.sda_oe;
    assign attention_pin_n_out = q.drive_lo;
    assign attention_pin_n_oe  = q.attn_oe;
    assign tx_optical_off      = q.tx_off;
    assign tx_mod_off          = q.tx_mod_off;
    assign squelch_mode_sel    = q.sq_mode;
    assign rx_output_off       = q.rx_off;
    assign low_power_mode      = q.low_pwr;
    assign mgmt_init_busy      = q.init_busy;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_fault_seen;
        !q.in_rst && q.cond_s2.tx_fault != 8'h00;
    endsequence
    sequence s_flag_pending;
        ((q.txf_flags & ~q.txf_mask) | (q.rxl_flags & ~q.rxl_mask)) != 8'h00;
    endsequence
    sequence s_loss_seen;
        !q.in_rst && q.cond_s2.rx_los != 8'h00;
    endsequence

    fault_flag_a: assert property (s_fault_seen |=>
        ((q.txf_flags & $past(q.cond_s2.tx_fault)) == $past(q.cond_s2.tx_fault)))
        else $error("fault flag not latched");
    fault_shut_a: assert property (s_fault_seen |-> ##2 (tx_optical_off != 4'h0))
        else $error("faulted lane not shut down");
    force_lp_a: assert property (q.ctrl[`MSC_BIT_FORCE_LP] |=> low_power_mode)
        else $error("forced low power ignored");
    lp_combo_a: assert property (!q.ctrl[`MSC_BIT_FORCE_LP] |=>
        (low_power_mode == ($past(q.ctrl[`MSC_BIT_SOFT_LP]) && $past(q.lp_s2))))
        else $error("low power combination wrong");
    pin_reset_a: assert property (!q.rst_s2 && !$past(q.rst_s2) && $rose(q.in_rst)
        |-> q.low_cnt == `MSC_LOWCNT_W'(`MSC_RST_MIN_CYC))
        else $error("reset taken before minimum pulse");
    attn_set_a: assert property (s_flag_pending |=> attention_pin_n_oe)
        else $error("attention not asserted");
    attn_rel_a: assert property (((q.txf_flags & ~q.txf_mask)
        | (q.rxl_flags & ~q.rxl_mask)) == 8'h00 |=> !attention_pin_n_oe)
        else $error("attention held without flag");
    rx_dis_a: assert property (q.rx_dis != 8'h00 |=>
        ((rx_output_off & $past(q.rx_dis)) == $past(q.rx_dis)))
        else $error("receiver disable ignored");
    pair_dis_a: assert property (q.tx_dis[1:0] != 2'b00 |=> tx_optical_off[0])
        else $error("pair disable ignored");
    init_done_a: assert property ($fell(q.in_rst) |-> q.init_cnt == INIT_CYCLES)
        else $error("init count not loaded");
    // With the pin high, only a control byte write may restart the block
    sw_reset_a: assert property ($rose(q.in_rst) && $past(q.rst_s2)
        |-> $past(q.bus) == MSC_WR)
        else $error("reset without pin or control write");
    busy_init_a: assert property (q.in_rst |=> mgmt_init_busy)
        else $error("busy not shown during reset");
    reset_clear_a: assert property (q.in_rst |=>
        (q.ctrl == 8'h00 && q.tx_dis == 8'h00 && q.rx_dis == 8'h00))
        else $error("settings survive reset");
    rx_squelch_a: assert property (q.cond_s2.rx_los != 8'h00 |=>
        ((rx_output_off & $past(q.cond_s2.rx_los)) == $past(q.cond_s2.rx_los)))
        else $error("receiver squelch missing");
    tx_squelch_a: assert property ($changed(q.cond_s2.tx_los) |=>
        tx_mod_off == $past(q.cond_s2.tx_los))
        else $error("transmitter squelch not followed");
    sq_mode_a: assert property ($changed(q.ctrl[`MSC_BIT_SQ_MODE]) |=>
        squelch_mode_sel == $past(q.ctrl[`MSC_BIT_SQ_MODE]))
        else $error("squelch mode not passed out");
    fault_keep_a: assert property (q.shutdown[1] && q.tx_dis[3:2] == 2'b00
        && !q.in_rst |=> q.shutdown[1])
        else $error("shutdown lifted without toggle");
    rx_flag_a: assert property (s_loss_seen |=>
        ((q.rxl_flags & $past(q.cond_s2.rx_los)) == $past(q.cond_s2.rx_los)))
        else $error("loss flag not latched");
    pair_top_a: assert property (q.tx_dis[7:6] != 2'b00 |=> tx_optical_off[3])
        else $error("upper pair disable ignored");

endmodule

// ---- verif/msc_host_model.sv ----
// Two-wire bus master standing in for the host system
`timescale 1ns/1ps
module msc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Bus
    input  wire logic sda_line,
    output logic      scl_drv,
    output logic      sda_low
);
    initial begin
        scl_drv = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Quarter of the 320 ns bus period, moved on the bench's drive edge
    task automatic q(input int n);
        repeat (2 * n) @(posedge ref_clk);
        #1;
    endtask
    // Data moves a quarter after the fall, so the slow synchroniser sees it settled
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        q(1);
        scl_drv = 1'b1;
        q(1);
        r = sda_line;
        q(1);
        scl_drv = 1'b0;
        q(1);
    endtask
    task automatic start();
        sda_low = 1'b0;
        q(1);
        scl_drv = 1'b1;
        q(2);
        sda_low = 1'b1;
        q(2);
        scl_drv = 1'b0;
        q(1);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q(1);
        scl_drv = 1'b1;
        q(2);
        sda_low = 1'b0;
        q(2);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Last byte of a read is refused by the master, ending the device's turn
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule

// ---- verif/module_soft_control_status_tb_top.sv ----
// Self-checking bench of the soft control block
`timescale 1ns/1ps
`include "msc_cfg.svh"
module module_soft_control_status_tb_top;
    import msc_pkg::*;
    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
        $display("[ERR] %0t %0h %0h", $time, a, b); end end
    logic           ref_clk = 1'b0;
    logic           resetn = 1'b0;
    logic           lp_pin = 1'b0;
    logic           rst_pin_n = 1'b1;
    logic           ack_chk = 1'b1;
    msc_lane_cond_t cond = '0;
    logic           scl, sda_low, sda_out, sda_oe, attn_out, attn_oe, sq_sel, lp_mode, busy;
    logic [3:0]     tx_off;
    logic [7:0]     mod_off, rx_off, v;
    int             bad_count = 0;
    int             checked = 0;
    int             cycles = 0;
    // Open drain with pull-up: low when either side pulls
    wire            sda_line = ~(sda_oe | sda_low);
    always #20 ref_clk = ~ref_clk;
    msc_host_model H (.ref_clk(ref_clk), .sda_line(sda_line), .scl_drv(scl), .sda_low(sda_low));
    msc_core #(.INIT_CYCLES(26'h14), .ADV_WAIT(8'h12), .ADV_DP(8'h34), .ADV_PWR(8'h56)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .scl_pin(scl), .sda_pin_in(sda_line),
        .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .module_select_pin_n(1'b0),
        .power_save_pin(lp_pin), .module_reset_pin_n(rst_pin_n),
        .attention_pin_n_out(attn_out), .attention_pin_n_oe(attn_oe), .lane_cond(cond),
        .tx_optical_off(tx_off), .tx_mod_off(mod_off), .squelch_mode_sel(sq_sel),
        .rx_output_off(rx_off), .low_power_mode(lp_mode), .mgmt_init_busy(busy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wb(input logic [7:0] d);
        logic ack;
        H.wr_byte(d, ack);
        if (ack_chk) `CHK(ack, 1'b1)
    endtask
    // Page is set in its own transfer so every access lands on a known half
    task automatic acc(input logic [7:0] pg, off, d, input logic wr, output logic [7:0] q);
        H.start();
        wb(8'hA0);
        wb(`MSC_OFF_PAGE);
        wb(pg);
        H.stop();
        H.start();
        wb(8'hA0);
        wb(off);
        if (wr) begin
            wb(d);
        end else begin
            H.start();
            wb(8'hA1);
            H.rd_byte(1'b1, q);
        end
        H.stop();
    endtask
    task automatic wr(input logic [7:0] pg, off, d);
        logic [7:0] q;
        acc(pg, off, d, 1'b1, q);
        cyc(4);
    endtask
    task automatic rc(input logic [7:0] pg, off, e);
        logic [7:0] q;
        acc(pg, off, 8'h00, 1'b0, q);
        `CHK(q, e)
        cyc(4);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        cyc(2);
        `CHK(busy, 1'b1)
        cyc(25);
        `CHK(busy, 1'b0)
        `CHK(attn_out, 1'b0)
        `CHK(sda_out, 1'b0)
        rc(8'h00, `MSC_OFF_CTRL, 8'h00);
        rc(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'h00);
    endtask
    task automatic t_power();
        for (int i = 0; i < 8; i++) begin
            lp_pin = i[0];
            v = {1'b0, i[1], i[0], i[2], 4'h0};
            wr(8'h00, `MSC_OFF_CTRL, v);
            `CHK(lp_mode, i[2] | (i[1] & i[0]))
            `CHK(sq_sel, i[0])
            rc(8'h00, `MSC_OFF_CTRL, v);
        end
    endtask
    task automatic t_lanes();
        for (int l = 0; l < 4; l++) begin
            wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'h01 << (2 * l + l % 2));
            `CHK(tx_off, 4'h1 << l)
        end
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'h00);
        `CHK(tx_off, 4'h0)
        wr(`MSC_PAGE_CTL, `MSC_OFF_RX_DIS, 8'hA5);
        `CHK(rx_off, 8'hA5)
        rc(`MSC_PAGE_CTL, `MSC_OFF_RX_DIS, 8'hA5);
        wr(`MSC_PAGE_CTL, `MSC_OFF_RX_DIS, 8'h00);
        `CHK(rx_off, 8'h00)
    endtask
    task automatic t_squelch();
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_SQ, 8'hFF);
        wr(`MSC_PAGE_CTL, `MSC_OFF_RX_SQ, 8'hFF);
        rc(`MSC_PAGE_CTL, `MSC_OFF_TX_SQ, 8'h00);
        rc(`MSC_PAGE_CTL, `MSC_OFF_RX_SQ, 8'h00);
        cond.tx_los = 8'h3C;
        cond.rx_los = 8'hC3;
        cyc(6);
        `CHK(mod_off, 8'h3C)
        `CHK(rx_off, 8'hC3)
        `CHK(attn_oe, 1'b1)
        wr(8'h00, `MSC_OFF_RXL_MASK, 8'hFF);
        `CHK(attn_oe, 1'b0)
        wr(8'h00, `MSC_OFF_RXL_MASK, 8'h00);
        `CHK(attn_oe, 1'b1)
        cond = '0;
        rc(`MSC_PAGE_FLG, `MSC_OFF_RXL, 8'hC3);
        `CHK(attn_oe, 1'b0)
        rc(`MSC_PAGE_FLG, `MSC_OFF_RXL, 8'h00);
    endtask
    task automatic t_fault();
        cond.tx_fault = 8'h04;
        cyc(6);
        `CHK(attn_oe, 1'b1)
        `CHK(tx_off, 4'h2)
        rc(`MSC_PAGE_FLG, `MSC_OFF_TXF, 8'h04);
        `CHK(attn_oe, 1'b1)
        cond.tx_fault = 8'h00;
        rc(`MSC_PAGE_FLG, `MSC_OFF_TXF, 8'h04);
        `CHK(attn_oe, 1'b0)
        rc(`MSC_PAGE_FLG, `MSC_OFF_TXF, 8'h00);
        `CHK(tx_off, 4'h2)
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'h08);
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'h00);
        `CHK(tx_off, 4'h0)
    endtask
    task automatic t_reset();
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'hFF);
        rst_pin_n = 1'b0;
        cyc(100);
        rst_pin_n = 1'b1;
        cyc(5);
        `CHK(tx_off, 4'hF)
        rst_pin_n = 1'b0;
        cyc(260);
        rst_pin_n = 1'b1;
        cyc(3);
        `CHK(busy, 1'b1)
        cyc(30);
        `CHK(tx_off, 4'h0)
        wr(`MSC_PAGE_CTL, `MSC_OFF_TX_DIS, 8'hFF);
        // The block restarts inside this write, so its last ack is not owed
        ack_chk = 1'b0;
        wr(8'h00, `MSC_OFF_CTRL, 8'h08);
        ack_chk = 1'b1;
        cyc(30);
        `CHK(tx_off, 4'h0)
        rc(8'h00, `MSC_OFF_CTRL, 8'h00);
    endtask
    task automatic t_adv();
        logic [7:0] offs [4] = '{`MSC_OFF_ADV_WAIT, `MSC_OFF_ADV_DP, `MSC_OFF_ADV_PWR, 8'h05};
        logic [7:0] exps [4] = '{8'h12, 8'h34, 8'h56, 8'h00};
        for (int i = 0; i < 4; i++) rc(`MSC_PAGE_ADV, offs[i], exps[i]);
    endtask
    initial begin
        cyc(5);
        resetn = 1'b1;
        t_init();
        t_power();
        t_lanes();
        t_squelch();
        t_fault();
        t_reset();
        t_adv();
        test_done();
    end
endmodule
